// file: inc/scp_pkg.sv
// constants, state codes and command codes for the serial register command port
// assumes nothing beyond a synthesis tool that reads packages
package scp_pkg;

    localparam int          BYTE_W        = 8;
    localparam int          SYNC_SCLK     = 0;
    localparam int          SYNC_CSN      = 1;
    localparam int          SYNC_SDI      = 2;
    localparam int          SYNC_SDIO     = 3;
    // chip select idles high, everything else low
    localparam logic [3:0]  PIN_SYNC_RESET = 4'h2;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [2:0]  BIT_FIRST     = 3'h0;
    localparam logic [7:0]  PTR_RESET     = 8'h00;
    localparam logic [7:0]  PTR_STEP      = 8'h01;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    // page select register, rewritten by the host when it changes page
    localparam logic [7:0]  PAGE_REG_ADDR = 8'h01;

    localparam logic [2:0]  CMD_SET_ADDR  = 3'h0;
    localparam logic [2:0]  CMD_WRITE     = 3'h2;
    localparam logic [2:0]  CMD_WRITE_INC = 3'h3;
    localparam logic [2:0]  CMD_READ      = 3'h4;
    localparam logic [2:0]  CMD_READ_INC  = 3'h5;
    localparam logic [7:0]  CMD_BURST     = 8'he0;

    // link timing, for reference by the bench and by latency reasoning
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          SCLK_PERIOD_NS = 80;

    typedef enum logic [6:0] {
        ST_CMD        = 7'h01,
        ST_SET_ADDR   = 7'h02,
        ST_WRITE      = 7'h04,
        ST_READ       = 7'h08,
        ST_BURST_ADDR = 7'h10,
        ST_BURST_DATA = 7'h20,
        ST_DRAIN      = 7'h40
    } scp_state_t;

endpackage

// file: inc/scp_link_if.sv
// byte level link between the pin shifter and the command decoder
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface scp_link_if;
    logic       csActive;
    logic       byteValid;
    logic [7:0] byteData;
    logic       txLoad;
    logic [7:0] txByte;
    logic       txActive;

    modport shifter (output csActive, output byteValid, output byteData,
                     input txLoad, input txByte, input txActive);
    modport control (input csActive, input byteValid, input byteData,
                     output txLoad, output txByte, output txActive);
endinterface

// file: hw/scp_shifter.sv
// pin synchronisers, serial clock edge finder and byte shifters
// assumes serial clock idles low, data sampled on its rising edge
`timescale 1ns/10ps
module scp_shifter
    import scp_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     resetn,
    input  wire logic     sclkPin,
    input  wire logic     chipSelectN,
    input  wire logic     serialInPin,
    input  wire logic     sdioIn,
    input  wire logic     threeWireSelect,
    output logic          serialOutPin,
    output logic          serialOutEn,
    output logic          sdioOut,
    output logic          sdioOe,
    scp_link_if.shifter   link
);

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic       sclkOld;
        logic [7:0] rx;
        logic [2:0] bitCnt;
        logic [7:0] tx;
        logic       byteValid;
        logic [7:0] byteData;
    } scp_shift_st_t;

    scp_shift_st_t q;
    scp_shift_st_t d;
    logic          din;
    logic          active;
    logic          rise;
    logic          fall;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.s1 = {sdioIn, serialInPin, chipSelectN, sclkPin};
        d.s2 = q.s1;
        d.sclkOld = q.s2[SYNC_SCLK];
        // shared pin carries host data in 3-wire mode
        din = threeWireSelect ? q.s2[SYNC_SDIO] : q.s2[SYNC_SDI];
        active = ~q.s2[SYNC_CSN];
        rise = q.s2[SYNC_SCLK] & ~q.sclkOld;
        fall = ~q.s2[SYNC_SCLK] & q.sclkOld;
        d.byteValid = 1'b0;
        if (!active) begin
            // a frame always starts on a byte boundary
            d.bitCnt = BIT_FIRST;
        end else if (rise) begin
            d.rx = {q.rx[6:0], din};                          // msb first
            d.bitCnt = q.bitCnt + 3'h1;
            if (q.bitCnt == BIT_LAST) begin
                d.byteValid = 1'b1;
                d.byteData = {q.rx[6:0], din};
            end
        end
        // no shift on the fall right after a byte ends: the loaded msb must
        // stand until the host samples it on the next rise
        if (link.txLoad) begin
            d.tx = link.txByte;
        end else if (active && fall && q.bitCnt != BIT_FIRST) begin
            d.tx = {q.tx[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.s1 <= PIN_SYNC_RESET;
            q.s2 <= PIN_SYNC_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign link.csActive  = ~q.s2[SYNC_CSN];
    assign link.byteValid = q.byteValid;
    assign link.byteData  = q.byteData;
    assign serialOutPin   = q.tx[7];
    assign sdioOut        = q.tx[7];
    assign serialOutEn    = ~threeWireSelect & link.txActive;
    assign sdioOe         = threeWireSelect & link.txActive;   // turn-taking

endmodule

// file: hw/scp_port.sv
// serial slave command port: decodes command bytes and drives register accesses
// assumes the register file answers rdData combinationally from ptrAddr
//
// How it works
// - 3-wire select chooses between 4-wire and 3-wire pin use.
// - 4-wire uses serial clock, chip select, separate data in and out.
// - 3-wire shares one data pin; host and device take turns driving.
// - Command 000x xxxx: next byte loads the 8-bit address pointer.
// - 010 writes next byte at pointer; 100 shifts out byte at pointer.
// - 011 writes next byte at pointer, then pointer plus one.
// - 101 returns byte at pointer, then pointer plus one.
// - 1110 0000 burst: start address, then data at sequential addresses.
// - Burst ends when chip select goes high; no more bytes taken.
// - Burst length unlimited; pointer wraps from 255 to zero.
`timescale 1ns/10ps
module scp_port
    import scp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       sclkPin,
    input  wire logic       chipSelectN,
    input  wire logic       serialInPin,
    input  wire logic       sdioIn,
    input  wire logic       threeWireSelect,
    output logic            serialOutPin,
    output logic            serialOutEn,
    output logic            sdioOut,
    output logic            sdioOe,
    output logic [7:0]      ptrAddr,
    input  wire logic [7:0] rdData,
    output logic            wrEn,
    output logic [7:0]      wrAddr,
    output logic [7:0]      wrData,
    output logic            cmdUnknown
);

    typedef struct packed {
        scp_state_t state;
        logic [7:0] ptr;
        logic       incFlag;
        logic       wrEn;
        logic [7:0] wrAddr;
        logic [7:0] wrData;
        logic       txLoad;
        logic [7:0] txByte;
        logic       txActive;
        logic       cmdUnknown;
    } scp_ctrl_st_t;

    scp_ctrl_st_t q;
    scp_ctrl_st_t d;
    scp_link_if   link ();

    ////////////////////////////////////////////////////////////////////////////
    scp_shifter u_shifter (
        .clock           (clock),
        .resetn          (resetn),
        .sclkPin         (sclkPin),
        .chipSelectN     (chipSelectN),
        .serialInPin     (serialInPin),
        .sdioIn          (sdioIn),
        .threeWireSelect (threeWireSelect),
        .serialOutPin    (serialOutPin),
        .serialOutEn     (serialOutEn),
        .sdioOut         (sdioOut),
        .sdioOe          (sdioOe),
        .link            (link.shifter)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.wrEn = 1'b0;
        d.txLoad = 1'b0;
        d.cmdUnknown = 1'b0;
        if (!link.csActive) begin
            // frame end closes any command, burst included; pointer kept
            d.state = ST_CMD;
            d.txActive = 1'b0;
            d.incFlag = 1'b0;
        end else if (link.byteValid) begin
            unique case (q.state)
                ST_CMD: begin
                    // low five bits are don't care except for burst
                    case (link.byteData[7:5])
                        CMD_SET_ADDR: begin
                            d.state = ST_SET_ADDR;
                        end
                        CMD_WRITE, CMD_WRITE_INC: begin
                            d.state = ST_WRITE;
                            d.incFlag = (link.byteData[7:5] == CMD_WRITE_INC);
                        end
                        CMD_READ, CMD_READ_INC: begin
                            // read data captured now so the msb is out before
                            // the host's next rising edge
                            d.state = ST_READ;
                            d.incFlag = (link.byteData[7:5] == CMD_READ_INC);
                            d.txLoad = 1'b1;
                            d.txByte = rdData;
                        end
                        default: begin
                            if (link.byteData == CMD_BURST) begin
                                d.state = ST_BURST_ADDR;
                            end else begin
                                // no burst read: unknown codes are swallowed
                                d.state = ST_DRAIN;
                                d.cmdUnknown = 1'b1;
                            end
                        end
                    endcase
                end
                ST_SET_ADDR: begin
                    d.ptr = link.byteData;
                    d.state = ST_DRAIN;
                end
                ST_WRITE: begin
                    d.wrEn = 1'b1;
                    d.wrAddr = q.ptr;
                    d.wrData = link.byteData;
                    if (q.incFlag) begin
                        d.ptr = q.ptr + PTR_STEP;
                    end
                    d.state = ST_DRAIN;
                end
                ST_READ: begin
                    // byte shifted out; drop the drive on the data pin
                    d.txActive = 1'b0;
                    if (q.incFlag) begin
                        d.ptr = q.ptr + PTR_STEP;
                    end
                    d.state = ST_DRAIN;
                end
                ST_BURST_ADDR: begin
                    d.ptr = link.byteData;
                    d.state = ST_BURST_DATA;
                end
                ST_BURST_DATA: begin
                    // eight-bit add wraps 255 to zero by itself
                    d.wrEn = 1'b1;
                    d.wrAddr = q.ptr;
                    d.wrData = link.byteData;
                    d.ptr = q.ptr + PTR_STEP;
                end
                ST_DRAIN: begin
                    // extra bytes after a single command are ignored
                    d.state = ST_DRAIN;
                end
            endcase
        end else if (q.txLoad) begin
            // drive the pin only once the shifter holds the read byte,
            // so the host never sees a stale bit on an enabled pin
            d.txActive = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.state <= ST_CMD;
            q.ptr <= PTR_RESET;
            q.txByte <= BYTE_ZERO;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign link.txLoad   = q.txLoad;
    assign link.txByte   = q.txByte;
    assign link.txActive = q.txActive;
    assign ptrAddr       = q.ptr;
    assign wrEn          = q.wrEn;
    assign wrAddr        = q.wrAddr;
    assign wrData        = q.wrData;
    assign cmdUnknown    = q.cmdUnknown;

endmodule

// file: bench/scp_port_props.sv
// assertions on the pins and register-file side of the serial command port
// assumes the single system clock and its active-low asynchronous reset
`timescale 1ns/10ps
module scp_port_props (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       chipSelectN,
    input wire logic       threeWireSelect,
    input wire logic       serialOutPin,
    input wire logic       serialOutEn,
    input wire logic       sdioOut,
    input wire logic       sdioOe,
    input wire logic [7:0] ptrAddr,
    input wire logic [7:0] rdData,
    input wire logic       wrEn
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    a_oe_excl: assert property (!(serialOutEn && sdioOe))
        else $error("both data outputs enabled");
    a_oe_four: assert property (serialOutEn |-> !threeWireSelect)
        else $error("data out driven in 3-wire mode");
    a_oe_three: assert property (sdioOe |-> threeWireSelect)
        else $error("shared pin driven in 4-wire mode");
    a_out_same: assert property (serialOutPin == sdioOut)
        else $error("data out and shared pin differ");
    a_read_msb: assert property ($rose(serialOutEn || sdioOe)
        |-> serialOutPin == $past(rdData[7]))
        else $error("read does not start with msb");
    a_wr_pulse: assert property (wrEn |=> !wrEn)
        else $error("write strobe longer than one cycle");
    a_cs_nowrite: assert property ($rose(chipSelectN) |-> ##6 (!wrEn) [*8])
        else $error("write after chip select high");
    a_cs_idle: assert property (chipSelectN [*6] |-> !(serialOutEn || sdioOe))
        else $error("output driven outside a frame");
    a_ptr_keep: assert property (chipSelectN [*8] |-> $stable(ptrAddr))
        else $error("pointer moved between frames");
endmodule
bind scp_port scp_port_props scp_port_props_i (.clock, .resetn, .chipSelectN,
    .threeWireSelect, .serialOutPin, .serialOutEn, .sdioOut, .sdioOe, .ptrAddr,
    .rdData, .wrEn);

// file: bench/scp_host_model.sv
// serial master model: mode 0, msb first, serial clock still between frames
// assumes the caller enters its tasks just after a rising clock edge
`timescale 1ns/10ps
module scp_host_model (
    input wire logic clock,
    input wire logic threeWire,
    input wire logic outWire,
    input wire logic sdioWire,
    output logic     sclk,
    output logic     csN,
    output logic     dat
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        dat  = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic csLow();
        csN <= 1'b0;
        wt(4);
    endtask
    // long gap lets the last byte land before the frame closes
    task automatic csHigh();
        wt(8);
        csN <= 1'b1;
        wt(8);
    endtask
    // sampled at the serial clock rise as mode 0 expects; the device moves
    // its data three clocks after a fall, one clock before the next rise
    task automatic xfer(input logic [7:0] tx, input bit drv, input int n,
                        output logic [7:0] rx);
        for (int i = 7; i >= 8 - n; i--) begin
            dat <= drv ? tx[i] : ~dat;
            wt(4);
            sclk <= 1'b1;
            rx[i] = threeWire ? sdioWire : outWire;
            wt(4);
            sclk <= 1'b0;
        end
    endtask
endmodule

// file: bench/scp_port_tb_top.sv
// self-checking bench: host model drives frames, a monitor checks writes
// assumes a register file answering rdData combinationally from ptrAddr
`timescale 1ns/10ps
module scp_port_tb_top;
    import scp_pkg::*;
    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    logic       threeWireSelect = 1'b0;
    logic       tog = 1'b0;
    logic       hostSclk, hostCsN, hostDat;
    logic       serialOutPin, serialOutEn, sdioOut, sdioOe, wrEn, cmdUnknown;
    logic [7:0] ptrAddr, rdData, wrAddr, wrData, rx, a, d;
    logic [7:0] mem [256];
    logic [7:0] expMem [256];
    logic [15:0] wq [$];
    int         fails = 0;
    int         num_checks = 0;
    int         unk = 0;
    wire        outWire = serialOutEn ? serialOutPin : tog;
    wire        sdioWire = sdioOe ? sdioOut : hostDat;
    assign rdData = mem[ptrAddr];
    always #5 clock = ~clock;
    always @(posedge clock) tog <= ~tog;
    ////////////////////////////////////////////////////////////////////////
    scp_port scp_port_i (.clock(clock), .resetn(resetn), .sclkPin(hostSclk),
        .chipSelectN(hostCsN), .serialInPin(hostDat), .sdioIn(sdioWire),
        .threeWireSelect(threeWireSelect), .serialOutPin(serialOutPin),
        .serialOutEn(serialOutEn), .sdioOut(sdioOut), .sdioOe(sdioOe),
        .ptrAddr(ptrAddr), .rdData(rdData), .wrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData), .cmdUnknown(cmdUnknown));
    scp_host_model scp_host_model_i (.clock(clock), .threeWire(threeWireSelect),
        .outWire(outWire), .sdioWire(sdioWire), .sclk(hostSclk), .csN(hostCsN),
        .dat(hostDat));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (e !== s) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic put(input logic [7:0] ad, input logic [7:0] dd);
        wq.push_back({ad, dd});
        expMem[ad] = dd;
    endtask
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input bit rd);
        scp_host_model_i.csLow();
        scp_host_model_i.xfer(b0, 1'b1, 8, rx);
        scp_host_model_i.xfer(b1, !rd, 8, rx);
        scp_host_model_i.csHigh();
    endtask
    // monitor: every write strobe must match the oldest noted write
    always @(negedge clock) begin
        if (cmdUnknown === 1'b1) unk++;
        if (wrEn === 1'b1) begin
            mem[wrAddr] <= wrData;
            if (wq.size() == 0) chk("spare write", 16'hxxxx, {wrAddr, wrData});
            else chk("write", wq.pop_front(), {wrAddr, wrData});
        end
    end
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hcacd));
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($urandom);
            expMem[i] = mem[i];
        end
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        d = 8'($urandom);
        put(PAGE_REG_ADDR, d);
        frame({CMD_SET_ADDR, 5'h00}, PAGE_REG_ADDR, 0);
        frame({CMD_WRITE, 5'h00}, d, 0);
        a = 8'($urandom);
        d = 8'($urandom);
        frame({CMD_SET_ADDR, 5'($urandom)}, a, 0);
        chk("set pointer", a, ptrAddr);
        put(a, d);
        frame({CMD_WRITE, 5'($urandom)}, d, 0);
        chk("write keeps pointer", a, ptrAddr);
        put(a, ~d);
        frame({CMD_WRITE_INC, 5'($urandom)}, ~d, 0);
        chk("write step", 8'(a + PTR_STEP), ptrAddr);
        for (int m = 0; m < 2; m++) begin
            threeWireSelect <= 1'(m);
            frame({CMD_SET_ADDR, 5'h1f}, a, 0);
            frame({m ? CMD_READ_INC : CMD_READ, 5'($urandom)}, 8'h00, 1);
            chk("read", expMem[a], rx);
            chk("read step", 8'(a + 8'(m)), ptrAddr);
        end
        scp_host_model_i.csLow();
        scp_host_model_i.xfer(CMD_BURST, 1'b1, 8, rx);
        scp_host_model_i.xfer(8'hfe, 1'b1, 8, rx);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            put(8'hfe + 8'(i), d);
            scp_host_model_i.xfer(d, 1'b1, 8, rx);
        end
        scp_host_model_i.xfer(8'h5a, 1'b1, 4, rx);
        scp_host_model_i.csHigh();
        chk("pending writes", 16'h0, 16'(wq.size()));
        frame(8'he1, 8'h33, 0);
        chk("unknown command", 16'h1, 16'(unk));
        frame({CMD_SET_ADDR, 5'h00}, 8'hfe, 0);
        for (int i = 0; i < 4; i++) begin
            frame({CMD_READ_INC, 5'h00}, 8'h00, 1);
            chk("sequential read", expMem[8'hfe + 8'(i)], rx);
        end
        end_of_test();
    end
endmodule
